// [iwfd_pkg.sv]
package iwfd_pkg;

  // Clock rate and the no-operation sequence length
  localparam int CLK_PERIOD_NS = 10;
  localparam int NOP_TIME_NS = 4000;
  localparam int NOP_CYCLES = NOP_TIME_NS / CLK_PERIOD_NS;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PADDR = 8'h04;
  localparam logic [7:0] REG_BANKSEL = 8'h08;
  localparam logic [7:0] REG_INDEX = 8'h0c;
  localparam logic [7:0] REG_UACC = 8'h10;
  localparam logic [7:0] REG_LACC = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_OPND = 8'h1c;
  localparam logic [7:0] REG_EADDR = 8'h20;
  localparam logic [7:0] REG_DWLO = 8'h24;
  localparam logic [7:0] REG_DWHI = 8'h28;
  localparam logic [7:0] REG_BUF0 = 8'h2c;
  localparam logic [7:0] REG_BUF1 = 8'h30;
  localparam logic [7:0] REG_LOGIC = 8'h34;
  localparam logic [7:0] REG_INSTR = 8'h38;

  // Field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_AUTOREC_BIT = 1;
  localparam int BANK_ACTIVE_BIT = 3;

  // Program address targets and steps
  localparam logic [14:0] FAULT_ADDR = 15'h0000;
  localparam logic [14:0] BOOT_ADDR = 15'h0080;
  localparam logic [14:0] INSTR_STEP = 15'h0001;
  localparam logic [14:0] BUF_SPAN = 15'h0003;
  localparam logic [14:0] BUF_W1_OFS = 15'h0002;

  // Major function codes
  localparam logic [5:0] OP_FMT2 = 6'h28;
  localparam logic [5:0] OP_LO_MIN = 6'h02;
  localparam logic [5:0] OP_LO_MAX = 6'h27;
  localparam logic [5:0] OP_HI_MIN = 6'h29;
  localparam logic [5:0] OP_HI_MAX = 6'h3e;
  localparam logic [5:0] OP_IDX_MAX = 6'h27;
  localparam logic [5:0] OP_DW_MIN = 6'h10;
  localparam logic [5:0] OP_DW_MAX = 6'h13;
  localparam logic [5:0] OP_CONST_SX = 6'h1e;
  localparam logic [5:0] OP_CONST_ZX = 6'h1f;
  localparam logic [5:0] OP_IRJP = 6'h18;
  localparam logic [5:0] OP_JP = 6'h1c;
  localparam logic [5:0] OP_IJP = 6'h2c;
  localparam logic [5:0] OP_JC_MIN = 6'h30;
  localparam logic [5:0] OP_OR = 6'h29;
  localparam logic [5:0] OP_AND = 6'h2a;
  localparam logic [5:0] OP_XOR = 6'h2b;

  // Minor function codes of the two-field format
  localparam logic [5:0] M_ILL_A = 6'h00;
  localparam logic [5:0] M_ILL_B = 6'h01;
  localparam logic [5:0] M_ILL_C = 6'h3f;
  localparam logic [5:0] M_NU_A_MIN = 6'h02;
  localparam logic [5:0] M_NU_A_MAX = 6'h08;
  localparam logic [5:0] M_NU_B = 6'h0c;
  localparam logic [5:0] M_NU_C = 6'h20;
  localparam logic [5:0] M_NU_D_MIN = 6'h34;
  localparam logic [5:0] M_NU_D_MAX = 6'h39;
  localparam logic [5:0] M_NU_E_MIN = 6'h3c;
  localparam logic [5:0] M_NU_E_MAX = 6'h3e;
  localparam logic [5:0] M_BUF_MIN = 6'h09;
  localparam logic [5:0] M_BUF_MAX = 6'h0b;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_IFETCH = 4'h1,
    ST_DECODE = 4'h2,
    ST_OPLO = 4'h3,
    ST_OPHI = 4'h4,
    ST_BUF0 = 4'h5,
    ST_BUF1 = 4'h6,
    ST_NOP = 4'h7,
    ST_DONE = 4'h8
  } iwfd_state_t;

  typedef enum logic [1:0] {
    LOP_AND = 2'h0,
    LOP_OR = 2'h1,
    LOP_XOR = 2'h2,
    LOP_CPL = 2'h3
  } iwfd_lop_t;

  typedef struct packed {
    logic legal;
    logic fmt2;
    logic useConst;
    logic signExt;
    logic indexed;
    logic dblWord;
    logic eligible;
  } iwfd_cls_t;

  typedef struct packed {
    logic fmt2;
    logic illegal;
    logic unused;
    logic bufStart;
    logic useConst;
    logic indexed;
    logic dblWord;
    logic bankUsed;
    logic [6:0] fnCode;
    logic [5:0] minor;
    logic [5:0] sel;
    logic [17:0] operand;
    logic [14:0] addr;
  } iwfd_dec_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } iwfd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } iwfd_apb_rsp_t;

  typedef struct packed {
    logic memRdReq;
    logic [14:0] memAddr;
  } iwfd_mem_req_t;

  typedef struct packed {
    iwfd_state_t state;
    logic [17:0] instr;
    logic [14:0] pAddr;
    logic [3:0] bankSel;
    logic autoRec;
    logic [17:0] index;
    logic [17:0] upperAcc;
    logic [17:0] lowerAcc;
    iwfd_dec_t dec;
    logic decValid;
    logic busy;
    logic [17:0] dwLo;
    logic [17:0] dwHi;
    logic [17:0] buf0;
    logic [17:0] buf1;
    logic [17:0] logicRes;
    logic [15:0] nopCnt;
    iwfd_mem_req_t memReq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } iwfd_regs_t;

  localparam iwfd_regs_t REGS_RESET = '0;

endpackage

// [iwfd_logic_unit.sv]
`timescale 1ns/1ps
module iwfd_logic_unit
  import iwfd_pkg::*;
(
  input wire logic [17:0] opA, // Accumulator side
  input wire logic [17:0] opB, // Operand side
  input wire iwfd_lop_t op, // Operator select
  output logic [17:0] res // Bitwise result
);

  // Bitwise operators and one's complement
  always_comb begin
    case (op)
      LOP_AND: res = opA & opB;
      LOP_OR: res = opA | opB;
      LOP_XOR: res = opA ^ opB;
      default: res = ~opB;
    endcase
  end

endmodule

// [iwfd_decoder.sv]
`timescale 1ns/1ps
// Functional notes
// - Opcode is the top six bits, operand field the low twelve.
// - Opcodes 02-47 and 51-76 octal are valid single-field codes.
// - Constant operand uses no memory access; field widened to 18 bits.
// - Address operand field gives low 12 bits of a 15-bit address.
// - Program-relative address takes bank from top three program address bits.
// - Bank-register address takes bank from the bank select register.
// - Eligible codes use bank-register address while bank select is active.
// - Opcode 50 octal is always the two-field format.
// - Two-field: sub-opcode six bits, selector six bits; no memory access except buffer start.
// - Buffer start fetches two control words from the next two cells.
// - Upper and lower accumulators, 18 bits each, link into 36 bits.
// - Index value is the active 18-bit index register contents.
// - Decoded opcode is held in a seven-bit function register.
// - Double word: higher address holds the upper half.
// - Logic unit does AND, OR, XOR and one's complement bitwise.
// - Address from an operand keeps only its low 15 bits.
// - Sign extension copies bit 11 into the upper six bits.
// - Illegal codes jump to fault or bootstrap entry per auto-recovery.
// - Unused codes idle four microseconds, then proceed.
module iwfd_decoder
  import iwfd_pkg::*;
#(
  parameter int NopCycles = NOP_CYCLES // Length of the no-operation sequence
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire iwfd_apb_req_t apbReq, // APB request
  output iwfd_apb_rsp_t apbRsp, // APB response
  output iwfd_mem_req_t memReq, // Core memory read request
  input wire logic memRdValid, // Core memory read data valid
  input wire logic [17:0] memRdData, // Core memory read data
  output iwfd_dec_t dec, // Decoded instruction
  output logic decValid, // Decoded instruction strobe
  output logic [35:0] accLinked, // Linked accumulator pair
  output logic busy // Decode sequence running
);

  iwfd_regs_t s_q;
  iwfd_regs_t s_d;
  iwfd_lop_t lopSel;
  logic [17:0] lopB;
  logic [17:0] lopRes;

  // Opcode classes of the single-field format
  function automatic iwfd_cls_t classify(input logic [5:0] f);
    iwfd_cls_t c;
    logic jump;
    c = '0;
    jump = (f == OP_IRJP) || (f == 6'(OP_IRJP + 6'h01)) || (f == OP_JP) ||
      (f == 6'(OP_JP + 6'h01)) || (f == OP_IJP) || (f == 6'(OP_IJP + 6'h01)) ||
      (f >= OP_JC_MIN && f <= OP_HI_MAX);
    c.fmt2 = (f == OP_FMT2);
    c.legal = (f >= OP_LO_MIN && f <= OP_LO_MAX) || (f >= OP_HI_MIN && f <= OP_HI_MAX);
    c.useConst = (f == OP_CONST_SX) || (f == OP_CONST_ZX);
    c.signExt = (f == OP_CONST_SX);
    c.indexed = f[0] && (f <= OP_IDX_MAX);
    c.dblWord = (f >= OP_DW_MIN) && (f <= OP_DW_MAX);
    c.eligible = c.legal && !c.useConst && !jump;
    return c;
  endfunction

  // Unused minor codes of the two-field format
  function automatic logic minorUnused(input logic [5:0] m);
    return (m >= M_NU_A_MIN && m <= M_NU_A_MAX) || (m == M_NU_B) || (m == M_NU_C) ||
      (m >= M_NU_D_MIN && m <= M_NU_D_MAX) || (m >= M_NU_E_MIN && m <= M_NU_E_MAX);
  endfunction

  // Mapped offsets are the aligned words up to the last register
  function automatic logic regHit(input logic [7:0] a);
    return (a <= REG_INSTR) && (a[1:0] == 2'h0);
  endfunction

  // Register read multiplexer
  function automatic logic [31:0] readReg(input iwfd_regs_t r, input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    if (a == REG_CTRL) begin
      v[CTRL_AUTOREC_BIT] = r.autoRec;
    end else if (a == REG_PADDR) begin
      v[14:0] = r.pAddr;
    end else if (a == REG_BANKSEL) begin
      v[3:0] = r.bankSel;
    end else if (a == REG_INDEX) begin
      v[17:0] = r.index;
    end else if (a == REG_UACC) begin
      v[17:0] = r.upperAcc;
    end else if (a == REG_LACC) begin
      v[17:0] = r.lowerAcc;
    end else if (a == REG_STATUS) begin
      v = {4'h0, r.dec.sel, r.dec.minor, 1'b0, r.dec.fnCode, 2'h0, r.dec.bankUsed,
        r.dec.bufStart, r.dec.unused, r.dec.fmt2, r.dec.illegal, r.busy};
    end else if (a == REG_OPND) begin
      v[17:0] = r.dec.operand;
    end else if (a == REG_EADDR) begin
      v[14:0] = r.dec.addr;
    end else if (a == REG_DWLO) begin
      v[17:0] = r.dwLo;
    end else if (a == REG_DWHI) begin
      v[17:0] = r.dwHi;
    end else if (a == REG_BUF0) begin
      v[17:0] = r.buf0;
    end else if (a == REG_BUF1) begin
      v[17:0] = r.buf1;
    end else if (a == REG_LOGIC) begin
      v[17:0] = r.logicRes;
    end else if (a == REG_INSTR) begin
      v[17:0] = r.instr;
    end
    return v;
  endfunction

  // Operator select and operand for the logic unit
  always_comb begin
    if (s_q.dec.fnCode == {1'b0, OP_AND}) begin
      lopSel = LOP_AND;
    end else if (s_q.dec.fnCode == {1'b0, OP_OR}) begin
      lopSel = LOP_OR;
    end else if (s_q.dec.fnCode == {1'b0, OP_XOR}) begin
      lopSel = LOP_XOR;
    end else begin
      lopSel = LOP_CPL;
    end
    lopB = s_q.dec.useConst ? s_q.dec.operand : s_q.dwLo;
  end

  iwfd_logic_unit u_lop (
    .opA(s_q.lowerAcc),
    .opB(lopB),
    .op(lopSel),
    .res(lopRes)
  );

  // Next state: register bus, then decode sequencer
  always_comb begin
    iwfd_cls_t c;
    logic [11:0] u;
    logic [17:0] cval;
    logic [14:0] base;
    logic [14:0] yAddr;
    logic wrEn;
    logic goReq;
    c = classify(s_q.instr[17:12]);
    u = s_q.instr[11:0];
    cval = c.signExt ? {{6{u[11]}}, u} : {6'h00, u};
    base = (c.eligible && s_q.bankSel[BANK_ACTIVE_BIT]) ?
      {s_q.bankSel[2:0], u} : {s_q.pAddr[14:12], u};
    yAddr = c.indexed ? 15'(base + s_q.index[14:0]) : base;
    s_d = s_q;
    goReq = 1'b0;
    wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite && s_q.pready && !s_q.pslverr;
    // APB slave: answer in the first access cycle
    s_d.pready = apbReq.psel && !apbReq.penable;
    s_d.pslverr = s_d.pready && !regHit(apbReq.paddr);
    s_d.prdata = s_d.pready ? readReg(s_q, apbReq.paddr) : '0;
    if (wrEn) begin
      if (apbReq.paddr == REG_CTRL) begin
        s_d.autoRec = apbReq.pwdata[CTRL_AUTOREC_BIT];
        goReq = apbReq.pwdata[CTRL_GO_BIT];
      end else if (apbReq.paddr == REG_PADDR) begin
        s_d.pAddr = apbReq.pwdata[14:0];
      end else if (apbReq.paddr == REG_BANKSEL) begin
        s_d.bankSel = apbReq.pwdata[3:0];
      end else if (apbReq.paddr == REG_INDEX) begin
        s_d.index = apbReq.pwdata[17:0];
      end else if (apbReq.paddr == REG_UACC) begin
        s_d.upperAcc = apbReq.pwdata[17:0];
      end else if (apbReq.paddr == REG_LACC) begin
        s_d.lowerAcc = apbReq.pwdata[17:0];
      end
    end
    // Decode sequencer
    case (s_q.state)
      ST_IDLE: begin
        if (goReq) begin
          s_d.busy = 1'b1;
          s_d.memReq = '{memRdReq: 1'b1, memAddr: s_q.pAddr};
          s_d.state = ST_IFETCH;
        end
      end
      ST_IFETCH: begin
        if (memRdValid) begin
          s_d.instr = memRdData;
          s_d.memReq.memRdReq = 1'b0;
          s_d.state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        s_d.dec = '0;
        s_d.dec.fmt2 = c.fmt2;
        if (c.fmt2) begin
          s_d.dec.fnCode = {1'b1, u[11:6]};
          s_d.dec.minor = u[11:6];
          s_d.dec.sel = u[5:0];
          s_d.dec.illegal = (u[11:6] == M_ILL_A) || (u[11:6] == M_ILL_B) ||
            (u[11:6] == M_ILL_C);
          s_d.dec.unused = minorUnused(u[11:6]);
          s_d.dec.bufStart = (u[11:6] >= M_BUF_MIN) && (u[11:6] <= M_BUF_MAX);
          s_d.dec.operand = {12'h000, u[5:0]};
        end else begin
          s_d.dec.fnCode = {1'b0, s_q.instr[17:12]};
          s_d.dec.illegal = !c.legal;
          s_d.dec.useConst = c.useConst;
          s_d.dec.indexed = c.indexed;
          s_d.dec.dblWord = c.dblWord;
          s_d.dec.bankUsed = c.eligible && s_q.bankSel[BANK_ACTIVE_BIT];
          s_d.dec.operand = c.useConst ?
            (c.indexed ? 18'(cval + s_q.index) : cval) : {3'h0, yAddr};
          s_d.dec.addr = c.useConst ? 15'h0000 : yAddr;
        end
        if (s_d.dec.illegal) begin
          s_d.state = ST_DONE;
        end else if (s_d.dec.unused) begin
          s_d.nopCnt = '0;
          s_d.state = ST_NOP;
        end else if (s_d.dec.bufStart) begin
          s_d.memReq = '{memRdReq: 1'b1, memAddr: 15'(s_q.pAddr + INSTR_STEP)};
          s_d.state = ST_BUF0;
        end else if (!c.fmt2 && !c.useConst) begin
          s_d.memReq = '{memRdReq: 1'b1, memAddr: yAddr};
          s_d.state = ST_OPLO;
        end else begin
          s_d.state = ST_DONE;
        end
      end
      ST_OPLO: begin
        if (memRdValid) begin
          s_d.dwLo = memRdData;
          if (s_q.dec.dblWord) begin
            s_d.memReq.memAddr = 15'(s_q.dec.addr + INSTR_STEP);
            s_d.state = ST_OPHI;
          end else begin
            s_d.memReq.memRdReq = 1'b0;
            s_d.state = ST_DONE;
          end
        end
      end
      ST_OPHI: begin
        if (memRdValid) begin
          s_d.dwHi = memRdData;
          s_d.memReq.memRdReq = 1'b0;
          s_d.state = ST_DONE;
        end
      end
      ST_BUF0: begin
        if (memRdValid) begin
          s_d.buf0 = memRdData;
          s_d.memReq.memAddr = 15'(s_q.pAddr + BUF_W1_OFS);
          s_d.state = ST_BUF1;
        end
      end
      ST_BUF1: begin
        if (memRdValid) begin
          s_d.buf1 = memRdData;
          s_d.memReq.memRdReq = 1'b0;
          s_d.state = ST_DONE;
        end
      end
      ST_NOP: begin
        s_d.nopCnt = 16'(s_q.nopCnt + 16'h0001);
        if (s_q.nopCnt == 16'(NopCycles - 1)) begin
          s_d.state = ST_DONE;
        end
      end
      ST_DONE: begin
        s_d.logicRes = lopRes;
        if (s_q.dec.illegal) begin
          s_d.pAddr = s_q.autoRec ? BOOT_ADDR : FAULT_ADDR;
        end else begin
          s_d.pAddr = 15'(s_q.pAddr + (s_q.dec.bufStart ? BUF_SPAN : INSTR_STEP));
        end
        s_d.busy = 1'b0;
        s_d.state = ST_IDLE;
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
    s_d.decValid = (s_d.state == ST_DONE) && (s_q.state != ST_DONE);
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= REGS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign apbRsp = '{prdata: s_q.prdata, pready: s_q.pready, pslverr: s_q.pslverr};
  assign memReq = s_q.memReq;
  assign dec = s_q.dec;
  assign decValid = s_q.decValid;
  assign accLinked = {s_q.upperAcc, s_q.lowerAcc};
  assign busy = s_q.busy;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  property p_fmt1_split;
    s_q.decValid && !s_q.dec.fmt2 |-> s_q.dec.fnCode == {1'b0, s_q.instr[17:12]};
  endproperty
  a_fmt1_split: assert property (p_fmt1_split)
    else $error("single-field opcode not taken from top six bits");

  property p_fmt2_fields;
    (s_q.state == ST_DECODE) && (s_q.instr[17:12] == OP_FMT2) |=>
      s_q.dec.fmt2 && (s_q.dec.minor == s_q.instr[11:6]) && (s_q.dec.sel == s_q.instr[5:0]);
  endproperty
  a_fmt2_fields: assert property (p_fmt2_fields)
    else $error("two-field format not decoded for code 50");

  property p_const_nomem;
    (s_q.state == ST_DECODE) && s_d.dec.useConst && !s_d.dec.illegal |=>
      !s_q.memReq.memRdReq ##1 (s_q.state == ST_IDLE);
  endproperty
  a_const_nomem: assert property (p_const_nomem)
    else $error("constant operand made a memory reference");

  property p_sign_ext;
    s_q.decValid && s_q.dec.useConst && !s_q.dec.indexed && !s_q.dec.fmt2 |->
      s_q.dec.operand[17:12] == {6{s_q.instr[11]}};
  endproperty
  a_sign_ext: assert property (p_sign_ext)
    else $error("constant sign extension wrong");

  property p_prog_rel;
    s_q.decValid && !s_q.dec.fmt2 && !s_q.dec.useConst && !s_q.dec.illegal &&
      !s_q.dec.indexed && !s_q.dec.bankUsed |->
      s_q.dec.addr == {s_q.pAddr[14:12], s_q.instr[11:0]};
  endproperty
  a_prog_rel: assert property (p_prog_rel)
    else $error("program-relative address wrong");

  property p_bank_reg;
    s_q.decValid && s_q.dec.bankUsed && !s_q.dec.indexed |->
      s_q.bankSel[BANK_ACTIVE_BIT] && (s_q.dec.addr[14:12] == s_q.bankSel[2:0]);
  endproperty
  a_bank_reg: assert property (p_bank_reg)
    else $error("bank-register address used wrongly");

  property p_nop_len;
    (s_q.state == ST_NOP) |=>
      ((s_q.state == ST_DONE) == ($past(s_q.nopCnt) == 16'(NopCycles - 1)));
  endproperty
  a_nop_len: assert property (p_nop_len)
    else $error("no-operation sequence length wrong");

  property p_illegal_jump;
    s_q.decValid && s_q.dec.illegal |=>
      s_q.pAddr == ($past(s_q.autoRec) ? BOOT_ADDR : FAULT_ADDR);
  endproperty
  a_illegal_jump: assert property (p_illegal_jump)
    else $error("illegal code did not reach fault or bootstrap entry");

  property p_buf_words;
    (s_q.state == ST_BUF0) && s_q.memReq.memRdReq |->
      (s_q.memReq.memAddr == 15'(s_q.pAddr + INSTR_STEP)) and
      (memRdValid |=> s_q.memReq.memAddr == 15'(s_q.pAddr + BUF_W1_OFS));
  endproperty
  a_buf_words: assert property (p_buf_words)
    else $error("buffer control words not read from next two cells");

  property p_dword_hi;
    (s_q.state == ST_OPHI) && s_q.memReq.memRdReq |->
      s_q.memReq.memAddr == 15'(s_q.dec.addr + INSTR_STEP);
  endproperty
  a_dword_hi: assert property (p_dword_hi)
    else $error("double-word upper half not at next address");

  property p_logic_or;
    (s_q.state == ST_DONE) && (s_q.dec.fnCode == {1'b0, OP_OR}) |=>
      s_q.logicRes == ($past(s_q.lowerAcc) | $past(s_q.dwLo));
  endproperty
  a_logic_or: assert property (p_logic_or)
    else $error("inclusive OR result wrong");

endmodule

// [iwfd_mem_model.sv]
`timescale 1ns/1ps
module iwfd_mem_model
  import iwfd_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic reset, // Reset
  input wire iwfd_mem_req_t memReq, // Read request
  input wire logic [3:0] latency, // Wait before answering
  output logic memRdValid, // Read data valid
  output logic [17:0] memRdData // Read data
);
  logic [17:0] mem [int];
  logic [3:0] cnt;

  // Answer a held request after the wait; idle data lines keep toggling
  always @(posedge sys_clk) begin
    if (reset || memReq.memRdReq !== 1'b1 || memRdValid) begin
      cnt <= 4'h0;
      memRdValid <= 1'b0;
      memRdData <= reset ? 18'h2aaaa : ~memRdData;
    end else if (cnt >= latency) begin
      memRdValid <= 1'b1;
      memRdData <= mem.exists(int'(memReq.memAddr)) ? mem[int'(memReq.memAddr)] : 18'h0;
    end else begin
      cnt <= cnt + 4'h1;
      memRdData <= ~memRdData;
    end
  end
endmodule

// [instruction_word_format_decode_tb.sv]
`timescale 1ns/1ps
module instruction_word_format_decode_tb;
  import iwfd_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  iwfd_apb_req_t apbReq = '0;
  iwfd_apb_rsp_t apbRsp;
  iwfd_mem_req_t memReq;
  iwfd_dec_t dec;
  iwfd_dec_t seen;
  logic memRdValid;
  logic decValid;
  logic busy;
  logic [17:0] memRdData;
  logic [35:0] accLinked;
  logic [3:0] lat = 4'h0;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int num_checks = 0;

  iwfd_decoder #(.NopCycles(4)) iwfd_decoder_i (.sys_clk(sys_clk), .reset(reset),
    .apbReq(apbReq), .apbRsp(apbRsp), .memReq(memReq), .memRdValid(memRdValid),
    .memRdData(memRdData), .dec(dec), .decValid(decValid), .accLinked(accLinked),
    .busy(busy));
  iwfd_mem_model iwfd_mem_model_i (.sys_clk(sys_clk), .reset(reset), .memReq(memReq),
    .latency(lat), .memRdValid(memRdValid), .memRdData(memRdData));

  // Clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Keep the decode shown at its strobe
  always @(posedge sys_clk) begin
    if (decValid === 1'b1) seen <= dec;
  end

  task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    if (n >= 20) mismatches++;
    apbReq <= '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [35:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, {4'h0, rd}, e);
  endtask

  // Start the word at p and wait for its decode strobe
  task automatic run(input logic [14:0] p, input logic [17:0] w, input logic ar);
    int n;
    n = 0;
    iwfd_mem_model_i.mem[int'(p)] = w;
    apb(1'b1, REG_PADDR, {17'h0, p});
    apb(1'b1, REG_CTRL, {30'h0, ar, 1'b1});
    while (decValid !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200) mismatches++;
    chk("busy", {35'h0, busy}, 36'h1);
    repeat (2) @(posedge sys_clk);
    chk("idle", {35'h0, busy}, 36'h0);
  endtask

  function automatic logic [14:0] ea(input logic [5:0] f, input logic [11:0] u,
      input logic [14:0] p, input logic [3:0] bs, input logic [17:0] ix);
    logic [14:0] a;
    a = bs[3] ? {bs[2:0], u} : {p[14:12], u};
    if (f[0] && f <= OP_IDX_MAX) a = a + ix[14:0];
    return a;
  endfunction

  task automatic end_of_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end

  initial begin
    logic [14:0] p;
    logic [17:0] m, m2, la;
    logic [5:0] f;
    logic [11:0] u;
    logic [3:0] bs;
    logic [17:0] ix;
    logic [5:0] ill [6];
    logic [5:0] lops [3];
    ill = '{6'h00, 6'h01, 6'h3f, M_ILL_A, M_ILL_B, M_ILL_C};
    lops = '{OP_OR, OP_AND, OP_XOR};
    void'($urandom(4));
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset state, unmapped and read-only places
    rdc(REG_STATUS, 36'h0, "status");
    apb(1'b0, 8'h3c, 32'h0);
    chk("slverr", {35'h0, err}, 36'h1);
    apb(1'b1, REG_STATUS, 32'hffff);
    rdc(REG_STATUS, 36'h0, "status ro");
    m = 18'($urandom);
    la = 18'($urandom);
    apb(1'b1, REG_UACC, {14'h0, m});
    apb(1'b1, REG_LACC, {14'h0, la});
    repeat (2) @(posedge sys_clk);
    chk("acc", accLinked, {m, la});
    // Random single-field words with operand addresses
    for (int i = 0; i < 16; i++) begin
      f = (i % 2) ? 6'($urandom_range(2, 15)) : 6'($urandom_range(32, 39));
      u = 12'($urandom);
      p = 15'($urandom_range(0, 32000));
      bs = 4'($urandom);
      ix = 18'($urandom);
      lat <= 4'($urandom_range(0, 3));
      apb(1'b1, REG_BANKSEL, {28'h0, bs});
      apb(1'b1, REG_INDEX, {14'h0, ix});
      iwfd_mem_model_i.mem[int'(ea(f, u, p, bs, ix))] = 18'($urandom);
      run(p, {f, u}, 1'b0);
      chk("fn", seen.fnCode, {1'b0, f});
      chk("addr", seen.addr, ea(f, u, p, bs, ix));
      chk("flags", {seen.fmt2, seen.illegal, seen.useConst, seen.indexed}, {3'h0, f[0]});
      rdc(REG_PADDR, p + INSTR_STEP, "next");
    end
    // Constants, then a jump that ignores the bank register
    run(15'h0100, {OP_CONST_SX, 12'h800}, 1'b0);
    chk("sx", {seen.useConst, seen.operand}, {1'b1, 18'h3f800});
    run(15'h0100, {OP_CONST_ZX, 12'h800}, 1'b0);
    chk("zx", seen.operand, 18'(18'h00800 + ix));
    rdc(REG_LOGIC, 18'(~(18'h00800 + ix)), "cpl");
    apb(1'b1, REG_BANKSEL, 32'hf);
    run(15'h5123, {OP_JP, 12'habc}, 1'b0);
    chk("jump", seen.addr, 15'h5abc);
    // Illegal codes of both formats with both recovery choices
    for (int i = 0; i < 6; i++) begin
      run(15'h0300, (i < 3) ? {ill[i], 12'h123} : {OP_FMT2, ill[i], 6'h05}, i[0]);
      chk("illegal", seen.illegal, 1'b1);
      rdc(REG_PADDR, i[0] ? BOOT_ADDR : FAULT_ADDR, "trap");
    end
    // Double word and logical operators against the lower accumulator
    apb(1'b1, REG_BANKSEL, 32'h0);
    m = 18'($urandom);
    m2 = 18'($urandom);
    iwfd_mem_model_i.mem['h2400] = m;
    iwfd_mem_model_i.mem['h2401] = m2;
    run(15'h2100, {OP_DW_MIN, 12'h400}, 1'b0);
    rdc(REG_DWLO, m, "dwlo");
    rdc(REG_DWHI, m2, "dwhi");
    foreach (lops[i]) begin
      m = 18'($urandom);
      iwfd_mem_model_i.mem['h2400] = m;
      run(15'h2100, {lops[i], 12'h400}, 1'b0);
      rdc(REG_LOGIC, (i == 0) ? (la | m) : (i == 1) ? (la & m) : (la ^ m), "logic");
    end
    // Two-field words: buffer start, register-only, unused
    m = 18'($urandom);
    m2 = 18'($urandom);
    iwfd_mem_model_i.mem['h0401] = m;
    iwfd_mem_model_i.mem['h0402] = m2;
    lat <= 4'h2;
    run(15'h0400, {OP_FMT2, M_BUF_MIN, 6'h2a}, 1'b0);
    chk("fmt2", {seen.fmt2, seen.bufStart, seen.fnCode, seen.sel}, {3'h7, M_BUF_MIN, 6'h2a});
    rdc(REG_BUF0, m, "buf0");
    rdc(REG_BUF1, m2, "buf1");
    rdc(REG_PADDR, 15'h0403, "bufnext");
    run(15'h0500, {OP_FMT2, 6'h0d, 6'h15}, 1'b0);
    chk("k", {seen.minor, seen.operand}, {6'h0d, 18'h15});
    run(15'h0500, {OP_FMT2, M_NU_B, 6'h00}, 1'b0);
    chk("unused", seen.unused, 1'b1);
    rdc(REG_PADDR, 15'h0501, "nopnext");
    end_of_test();
  end
endmodule
